// file: design/watchdog_cfg.svh
`ifndef WATCHDOG_CFG_SVH
`define WATCHDOG_CFG_SVH

// Register offsets, given as indices and as byte addresses; byte address is four times the index.
`define WDT_CTRL_INDEX        16'hffb4
`define WDT_CNT_INDEX         16'hffb5
`define WDT_CTRL_ADDR         18'h3fed0
`define WDT_CNT_ADDR          18'h3fed4
`define WDT_IRQ_STATUS_ADDR   18'h3fed8
`define WDT_IRQ_MASK_ADDR     18'h3fedc
`define WDT_MODE_ADDR         18'h3fee0
`define WDT_ADDR_W            18

// Control register fields and reset values.
`define WDT_CTRL_RESET        8'haa
`define WDT_CNT_RESET         8'h00
`define WDT_BIT_CWE_INH       7
`define WDT_BIT_CWE           6
`define WDT_BIT_RWE_INH       5
`define WDT_BIT_RWE           4
`define WDT_BIT_EN_INH        3
`define WDT_BIT_EN            2
`define WDT_BIT_FLAG_INH      1
`define WDT_BIT_FLAG          0

// Timing counts.
`define WDT_PRESCALE          8192
`define WDT_RESET_OSC_CYCLES  512

// Bus responses.
`define AXI_RESP_OKAY         2'h0
`define AXI_RESP_SLVERR       2'h2

`endif

// file: design/watchdog_pkg.sv
package watchdog_pkg;

  // Active and low-power operating modes of the surrounding chip.
  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_SLEEP,
    MODE_WATCH,
    MODE_SUBACTIVE,
    MODE_SUBSLEEP,
    MODE_STANDBY
  } power_mode_t;

  // Reset pulse generator states.
  typedef enum logic [0:0] {
    RST_IDLE,
    RST_PULSE
  } rst_state_t;

  // Write address channel.
  typedef struct packed {
    logic        valid;
    logic [17:0] addr;
  } axi_aw_t;

  // Write data channel.
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic [3:0]  strb;
  } axi_w_t;

  // Read answer.
  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } axi_r_t;

endpackage

// file: design/watchdog_reset_timer.sv
// Summary of operation
// R01: Counter steps once per 8192 system clocks while the watchdog is enabled.
// R02: Counter wrap from ff to 00 raises internal reset and sets flag; code does neither if a blocked counter write hits that cycle.
// R03: Overflow reset is driven out as a chip-wide reset.
// R04: Overflow reset stays asserted for exactly 512 oscillator clocks.
// R05: Written counter value becomes the count; counting resumes from it.
// R06: Counter writes take effect only while counter write enable is 1.
// R07: Bits 7, 5, 3, 1 always read 1 and store nothing.
// R08: Counter write enable changes only when bit 7 is written 0.
// R09: Register write enable changes only when bit 5 is written 0.
// R10: Bits 2 and 0 change only while register write enable is 1.
// R11: Watchdog enable changes with enable and bit 3 zero; reset clears.
// R12: Enable 1 starts counting; enable 0 halts and holds count.
// R13: Flag cleared by pin reset or guarded 0 write; software cannot set.
// R14: Reset gives counter 00 and control register aa.
// R15: Counter runs in active and sleep only; control kept in all modes.
// R16: Overflow reset does not clear the watchdog reset flag.
// R17: One write sees the enables in force before that write.
`timescale 1ns/100ps
`include "watchdog_cfg.svh"

module watchdog_reset_timer #(
  parameter int PRESCALE   = `WDT_PRESCALE,
  parameter int RST_CYCLES = `WDT_RESET_OSC_CYCLES
) (
  // Clock and reset.
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      external_reset_pin_n,
  // Oscillator clock, sampled.
  input  wire logic                      osc_clk,
  // Write address channel.
  input  wire logic                      s_axi_awvalid,
  output      logic                      s_axi_awready,
  input  wire logic [`WDT_ADDR_W-1:0]    s_axi_awaddr,
  // Write data channel.
  input  wire logic                      s_axi_wvalid,
  output      logic                      s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  // Write response channel.
  output      logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output      logic [1:0]                s_axi_bresp,
  // Read address channel.
  input  wire logic                      s_axi_arvalid,
  output      logic                      s_axi_arready,
  input  wire logic [`WDT_ADDR_W-1:0]    s_axi_araddr,
  // Read data channel.
  output      logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output      watchdog_pkg::axi_r_t      s_axi_r,
  // System outputs.
  output      logic                      chip_reset,
  output      logic                      irq
);
  import watchdog_pkg::*;

  localparam int PW = $clog2(PRESCALE);
  localparam int RW = $clog2(RST_CYCLES + 1);

  initial begin
    if (PRESCALE < 2 || RST_CYCLES < 1) begin
      $error("watchdog_reset_timer: bad parameter values");
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------
  logic [1:0] pin_sync_reg;
  logic [1:0] osc_sync_reg;
  logic       osc_last_reg;
  logic       pin_reset;
  logic       osc_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync_reg <= 2'h3;
      osc_sync_reg <= 2'h0;
      osc_last_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], external_reset_pin_n};
      osc_sync_reg <= {osc_sync_reg[0], osc_clk};
      osc_last_reg <= osc_sync_reg[1];
    end
  end

  assign pin_reset = !pin_sync_reg[1];
  assign osc_rise  = osc_sync_reg[1] && !osc_last_reg;

  // ----------------------------------------------------------------
  // Bus write and read decode.
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [`WDT_ADDR_W-1:0] a);
    mapped = (a == `WDT_CTRL_ADDR) || (a == `WDT_CNT_ADDR) ||
             (a == `WDT_IRQ_STATUS_ADDR) || (a == `WDT_IRQ_MASK_ADDR) ||
             (a == `WDT_MODE_ADDR);
  endfunction

  axi_aw_t                 aw_reg;
  axi_w_t                  w_reg;
  logic                    wr_go;
  logic [7:0]              wd;
  logic                    wr_ctrl;
  logic                    wr_cnt;
  logic                    wr_mask;
  logic                    wr_mode;

  assign s_axi_awready = !aw_reg.valid && !s_axi_bvalid;
  assign s_axi_wready  = !w_reg.valid && !s_axi_bvalid;
  assign wr_go   = aw_reg.valid && w_reg.valid && !s_axi_bvalid;
  assign wd      = w_reg.data[7:0];
  assign wr_ctrl = wr_go && w_reg.strb[0] && aw_reg.addr == `WDT_CTRL_ADDR;
  assign wr_cnt  = wr_go && w_reg.strb[0] && aw_reg.addr == `WDT_CNT_ADDR;
  assign wr_mask = wr_go && w_reg.strb[0] &&
                   aw_reg.addr == `WDT_IRQ_MASK_ADDR;
  assign wr_mode = wr_go && w_reg.strb[0] && aw_reg.addr == `WDT_MODE_ADDR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg       <= '0;
      w_reg        <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_reg <= '{valid: 1'b1, addr: s_axi_awaddr};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_reg <= '{valid: 1'b1, data: s_axi_wdata, strb: s_axi_wstrb};
      end
      if (wr_go) begin
        aw_reg.valid <= 1'b0;
        w_reg.valid  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_reg.addr) ? `AXI_RESP_OKAY
                                            : `AXI_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register and power mode.
  // ----------------------------------------------------------------
  logic        cwe_reg;
  logic        rwe_reg;
  logic        en_reg;
  logic        flag_reg;
  power_mode_t mode_reg;
  logic        ovf;
  logic [7:0]  ctrl_view;

  // The flag clears on the pin reset or a guarded 0 write, not on the watchdog reset.
  always_ff @(posedge aclk) begin
    if (!aresetn || pin_reset) begin
      flag_reg <= 1'b0;                                       // [R13] [R14]
    end else if (ovf) begin
      flag_reg <= 1'b1;                                       // [R02] [R16]
    end else if (wr_ctrl && rwe_reg && !wd[`WDT_BIT_FLAG_INH] &&
                 !wd[`WDT_BIT_FLAG]) begin
      flag_reg <= 1'b0;                                       // [R13] [R17]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || pin_reset || chip_reset) begin
      cwe_reg <= 1'b0;                                        // [R14]
      rwe_reg <= 1'b0;
      en_reg  <= 1'b0;                                        // [R11]
    end else if (wr_ctrl) begin
      if (!wd[`WDT_BIT_CWE_INH]) begin
        cwe_reg <= wd[`WDT_BIT_CWE];                          // [R08]
      end
      if (!wd[`WDT_BIT_RWE_INH]) begin
        rwe_reg <= wd[`WDT_BIT_RWE];                          // [R09]
      end
      if (rwe_reg && !wd[`WDT_BIT_EN_INH]) begin
        en_reg <= wd[`WDT_BIT_EN];                            // [R10] [R11] [R17]
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= MODE_ACTIVE;
    end else if (wr_mode) begin
      mode_reg <= power_mode_t'(wd[2:0]);
    end
  end

  assign ctrl_view = {1'b1, cwe_reg, 1'b1, rwe_reg,
                      1'b1, en_reg, 1'b1, flag_reg};          // [R07]

  // ----------------------------------------------------------------
  // Prescaler and counter.
  // ----------------------------------------------------------------
  logic [PW-1:0] pre_reg;
  logic [7:0]    cnt_reg;
  logic          run;
  logic          tick;

  assign run  = en_reg && !chip_reset &&
                (mode_reg == MODE_ACTIVE || mode_reg == MODE_SLEEP); // [R12] [R15]
  assign tick = run && pre_reg == PW'(PRESCALE - 1);                // [R01]
  assign ovf  = tick && cnt_reg == 8'hff && !wr_cnt;                // [R02]

  always_ff @(posedge aclk) begin
    if (!aresetn || pin_reset || chip_reset || !run) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= tick ? '0 : pre_reg + 1'b1;                  // [R01]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || pin_reset || chip_reset) begin
      cnt_reg <= `WDT_CNT_RESET;                              // [R14]
    end else if (wr_cnt && cwe_reg) begin
      cnt_reg <= wd;                                          // [R05] [R06] [R17]
    end else if (tick) begin
      cnt_reg <= cnt_reg + 8'h01;                             // [R01] [R12]
    end
  end

  // ----------------------------------------------------------------
  // Overflow reset pulse.
  // ----------------------------------------------------------------
  rst_state_t    rst_state_reg;
  logic [RW-1:0] rst_cnt_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn || pin_reset) begin
      rst_state_reg <= RST_IDLE;
      rst_cnt_reg   <= '0;
    end else begin
      case (rst_state_reg)
        RST_IDLE: begin
          if (ovf) begin
            rst_state_reg <= RST_PULSE;                       // [R02]
            rst_cnt_reg   <= '0;
          end
        end
        RST_PULSE: begin
          if (osc_rise) begin
            if (rst_cnt_reg == RW'(RST_CYCLES - 1)) begin
              rst_state_reg <= RST_IDLE;                      // [R04]
            end
            rst_cnt_reg <= rst_cnt_reg + 1'b1;
          end
        end
        default: rst_state_reg <= RST_IDLE;
      endcase
    end
  end

  assign chip_reset = rst_state_reg == RST_PULSE;             // [R03]

  // ----------------------------------------------------------------
  // Interrupt status and mask.
  // ----------------------------------------------------------------
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic       rd_stat;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
    end else begin
      irq_stat_reg <= (rd_stat ? 2'h0 : irq_stat_reg) | {tick, ovf};
      if (wr_mask) begin
        irq_mask_reg <= wd[1:0];
      end
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // Read channel.
  // ----------------------------------------------------------------
  logic [7:0] rd_val;

  always_comb begin
    case (s_axi_araddr)
      `WDT_CTRL_ADDR:       rd_val = ctrl_view;
      `WDT_CNT_ADDR:        rd_val = cnt_reg;
      `WDT_IRQ_STATUS_ADDR: rd_val = {6'h00, irq_stat_reg};
      `WDT_IRQ_MASK_ADDR:   rd_val = {6'h00, irq_mask_reg};
      `WDT_MODE_ADDR:       rd_val = {5'h00, mode_reg};
      default:              rd_val = 8'h00;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_stat = s_axi_arvalid && s_axi_arready &&
                   s_axi_araddr == `WDT_IRQ_STATUS_ADDR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_r      <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_r.data <= {24'h000000, rd_val};
      s_axi_r.resp <= mapped(s_axi_araddr) ? `AXI_RESP_OKAY
                                           : `AXI_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // watchdog_reset_timer

// file: testbench/watchdog_reset_timer_assertions.sv
`timescale 1ns/100ps
module watchdog_reset_timer_assertions #(
  parameter int PRESCALE   = 4,
  parameter int RST_CYCLES = 4
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes.
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // System outputs.
  input wire logic chip_reset
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [15:0] hi_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || !chip_reset) begin
      hi_cnt <= 16'h0;
    end else begin
      hi_cnt <= hi_cnt + 16'h1;
    end
  end
  AST_RST_MIN: assert property ($rose(chip_reset) |-> chip_reset [*8])
    else $error("reset pulse too short");
  AST_RST_MAX: assert property (hi_cnt <= 16'(16 * RST_CYCLES + 8))
    else $error("reset pulse too long");
  AST_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken during response");
  AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped");
  AST_R_CAUSE: assert property ($rose(s_axi_rvalid) |->
    $past(s_axi_arvalid) && $past(s_axi_arready))
    else $error("read response without request");
  AST_B_CAUSE: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_wready))
    else $error("write response without data");
endmodule // watchdog_reset_timer_assertions

bind watchdog_reset_timer watchdog_reset_timer_assertions #(
  .PRESCALE(PRESCALE), .RST_CYCLES(RST_CYCLES)
) i_watchdog_reset_timer_assertions (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .chip_reset(chip_reset)
);

// file: testbench/watchdog_reset_timer_test.sv
`timescale 1ns/100ps
`include "watchdog_cfg.svh"
module watchdog_reset_timer_test;
  import watchdog_pkg::*;
  logic aclk, aresetn, pin_n, osc_clk, awvalid, awready, wvalid, wready;
  logic bvalid, bready, arvalid, arready, rvalid, rready, chip_reset, irq;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, r;
  axi_r_t      rbus;
  logic [7:0]  d, v;
  logic        a;
  int          miscompares, compares, cycles, n;
  always #25 aclk = ~aclk;
  always #100 osc_clk = ~osc_clk;
  watchdog_reset_timer #(.PRESCALE(4), .RST_CYCLES(4)) i_watchdog_reset_timer (
    .aclk(aclk), .aresetn(aresetn), .external_reset_pin_n(pin_n),
    .osc_clk(osc_clk), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_r(rbus), .chip_reset(chip_reset), .irq(irq)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [17:0] ad, input logic [7:0] dt);
    logic aw_on;
    logic w_on;
    logic b_on;
    @(posedge aclk);
    aw_on = 1'b1;
    w_on = 1'b1;
    b_on = 1'b1;
    awaddr <= ad;
    wdata <= {24'h0, dt};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_on || w_on || b_on) begin
      @(posedge aclk);
      if (aw_on && awready) begin
        awvalid <= 1'b0;
        aw_on = 1'b0;
      end
      if (w_on && wready) begin
        wvalid <= 1'b0;
        w_on = 1'b0;
      end
      if (b_on && bvalid) begin
        bready <= 1'b0;
        b_on = 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [17:0] ad);
    logic ar_on;
    logic r_on;
    @(posedge aclk);
    ar_on = 1'b1;
    r_on = 1'b1;
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (ar_on || r_on) begin
      @(posedge aclk);
      if (ar_on && arready) begin
        arvalid <= 1'b0;
        ar_on = 1'b0;
      end
      if (r_on && rvalid) begin
        rready <= 1'b0;
        r_on = 1'b0;
        d = rbus.data[7:0];
        r = rbus.resp;
      end
    end
  endtask
  task automatic t_guards;
    rd(`WDT_CTRL_ADDR); chk(d, 8'haa);
    rd(`WDT_CNT_ADDR); chk(d, 8'h00);
    rd(18'h00010); chk({6'h0, r}, 8'h02);
    wr(`WDT_CNT_ADDR, 8'h33); rd(`WDT_CNT_ADDR); chk(d, 8'h00);
    wr(`WDT_CTRL_ADDR, 8'hff); rd(`WDT_CTRL_ADDR); chk(d, 8'haa);
    wr(`WDT_CTRL_ADDR, 8'h54); rd(`WDT_CTRL_ADDR); chk(d, 8'hfa);
    wr(`WDT_CTRL_ADDR, 8'h54); rd(`WDT_CTRL_ADDR); chk(d, 8'hfe);
    $display("test guards done");
  endtask
  task automatic t_count;
    wr(`WDT_MODE_ADDR, 8'h02);
    wr(`WDT_CNT_ADDR, 8'h40);
    repeat (40) @(posedge aclk);
    rd(`WDT_CNT_ADDR); chk(d, 8'h40);
    wr(`WDT_MODE_ADDR, 8'h00);
    wr(`WDT_IRQ_MASK_ADDR, 8'h03);
    repeat (40) @(posedge aclk);
    a = irq;
    rd(`WDT_IRQ_STATUS_ADDR);
    wr(`WDT_IRQ_MASK_ADDR, 8'h00);
    repeat (20) @(posedge aclk);
    chk({7'h0, a ^ irq}, 8'h01);
    rd(`WDT_CNT_ADDR); chk({7'h0, d > 8'h40}, 8'h01);
    wr(`WDT_CTRL_ADDR, 8'h50);
    rd(`WDT_CNT_ADDR);
    v = d;
    repeat (40) @(posedge aclk);
    rd(`WDT_CNT_ADDR); chk(d, v);
    $display("test count done");
  endtask
  task automatic t_overflow;
    wr(`WDT_CNT_ADDR, 8'hfe);
    wr(`WDT_CTRL_ADDR, 8'h54);
    for (n = 0; n < 200 && !chip_reset; n++) @(posedge aclk);
    chk({7'h0, chip_reset}, 8'h01);
    for (n = 0; n < 400 && chip_reset; n++) @(posedge aclk);
    rd(`WDT_CTRL_ADDR); chk(d, 8'hab);
    rd(`WDT_CNT_ADDR); chk(d, 8'h00);
    wr(`WDT_CTRL_ADDR, 8'h50); rd(`WDT_CTRL_ADDR); chk(d, 8'hfb);
    wr(`WDT_CTRL_ADDR, 8'h50); rd(`WDT_CTRL_ADDR); chk(d, 8'hfa);
    $display("test overflow done");
  endtask
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    {aclk, aresetn, osc_clk, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, miscompares, compares, cycles} = '0;
    wstrb = 4'h1;
    pin_n = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_guards();
    t_count();
    t_overflow();
    tally_and_finish();
  end
endmodule // watchdog_reset_timer_test
